// File: logic/spiwd_pkg.sv
`default_nettype none
package spiwd_pkg;
    // -------------------------------------------------------------
    // Opcodes, shifted in MSB first
    // -------------------------------------------------------------
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
    localparam logic [7:0] OP_HIGH_MASK    = 8'hf7;
    localparam int         ADDR_HIGH_POS   = 3;

    // -------------------------------------------------------------
    // Status register layout and reset values
    // -------------------------------------------------------------
    localparam int         ST_LATCH_POS   = 1;
    localparam int         ST_PROT_POS    = 2;
    localparam int         ST_WD_POS      = 4;
    localparam logic [7:0] ST_BUSY_VIEW   = 8'hff;
    localparam logic [1:0] PROT_RESET     = 2'h0;
    localparam logic [1:0] WD_RESET       = 2'h3;
    localparam logic [1:0] WD_OFF         = 2'h3;
    localparam logic [3:0] PIN_FLT_RESET  = 4'hb;

    // -------------------------------------------------------------
    // Bit counts within a frame
    // -------------------------------------------------------------
    localparam logic [6:0] CNT_OPCODE     = 7'h08;
    localparam logic [6:0] CNT_ADDR       = 7'h10;
    localparam logic [6:0] CNT_PAGE_MIN   = 7'h18;
    localparam logic [6:0] CNT_PAGE_MAX   = 7'h30;
    localparam logic [6:0] CNT_SAT        = 7'h7f;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_NS      = 5000000;
    localparam int WRITE_CYCLES  = WRITE_NS / CLK_PERIOD_NS;
    localparam int TICK_MS       = 1;
    localparam int WD_LONG_MS    = 1400;
    localparam int WD_MID_MS     = 600;
    localparam int WD_SHORT_MS   = 200;
    localparam int HOLD_MS       = 200;
    localparam logic [10:0] WD_LONG_TICKS  = 11'(WD_LONG_MS / TICK_MS);
    localparam logic [10:0] WD_MID_TICKS   = 11'(WD_MID_MS / TICK_MS);
    localparam logic [10:0] WD_SHORT_TICKS = 11'(WD_SHORT_MS / TICK_MS);
    localparam logic [10:0] HOLD_TICKS     = 11'(HOLD_MS / TICK_MS);

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef enum logic [0:0] {
        WE_IDLE = 1'b0,
        WE_BUSY = 1'b1
    } spiwd_wstate_e;

    typedef struct packed {
        logic [7:0] opcode;
        logic [8:0] addr;
        logic [3:0] mask;
    } spiwd_frame_s;

    typedef struct packed {
        logic [1:0] wd;
        logic [1:0] prot;
        logic       latch;
    } spiwd_status_s;

    // Locked segment test for one byte address
    function automatic logic spiwd_locked(input logic [1:0] prot, input logic [8:0] addr);
        case (prot)
            2'h1:    spiwd_locked = (addr[8:7] == 2'h3);
            2'h2:    spiwd_locked = addr[8];
            2'h3:    spiwd_locked = 1'b1;
            default: spiwd_locked = 1'b0;
        endcase
    endfunction
endpackage
`default_nettype wire

// File: logic/spiwd_top.sv
`timescale 1ns/1ps
`default_nettype none
module spiwd_top
    import spiwd_pkg::*;
#(
    parameter int TICK_LEN  = TICK_CYCLES,
    parameter int WRITE_LEN = WRITE_CYCLES
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    output logic      so_o,
    output logic      so_oe,
    input  wire logic wp_n,
    input  wire logic supply_ok,
    input  wire logic reset_n_i,
    output logic      reset_n_o,
    output logic      reset_n_oe
);
    // ---------------------------------------------------------------
    // Link side, clocked by SCK
    // ---------------------------------------------------------------
    logic         in_frame;
    logic         frame_tgl;
    logic [6:0]   bit_cnt;
    logic [2:0]   phase;
    logic [6:0]   shreg;
    logic [1:0]   ptr;
    logic [8:0]   rd_addr;
    logic [7:0]   st_data;
    logic [7:0]   page_buf [0:3];
    logic [7:0]   mem      [0:511];
    logic         tx_on;
    logic         so_q;
    spiwd_frame_s frm;

    wire [7:0] next_byte  = {shreg, si};
    wire [6:0] next_cnt   = !in_frame ? 7'h01 : (bit_cnt == CNT_SAT) ? bit_cnt : bit_cnt + 7'h01;
    wire [2:0] next_phase = in_frame ? phase + 3'h1 : 3'h1;
    wire       boundary   = (next_phase == 3'h0);
    wire       op_is_wr   = ((frm.opcode & OP_HIGH_MASK) == OP_ARRAY_WRITE);
    wire       op_is_rd   = ((frm.opcode & OP_HIGH_MASK) == OP_ARRAY_READ);
    wire       op_is_st   = (frm.opcode == OP_STATUS_READ);

    // Frame flag: cleared by the select itself, so no SCK edge is needed
    // first edge opens frame
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // One toggle per clocked frame tells the core a frame really ran
    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            frame_tgl <= 1'b0;
        end else if (!in_frame) begin
            frame_tgl <= ~frame_tgl;
        end
    end

    // Shift path; holds its values after deselect so the core can judge them
    // capture on rising SCK
    always_ff @(posedge sck) begin
        bit_cnt <= next_cnt;
        phase   <= next_phase;
        shreg   <= next_byte[6:0];
        if (boundary) begin
            if (next_cnt == CNT_OPCODE) begin
                frm.opcode <= next_byte;
                frm.mask   <= 4'h0;
            end
            if (next_cnt == CNT_ADDR) begin
                // opcode bit 3 as high address
                frm.addr <= {frm.opcode[ADDR_HIGH_POS], next_byte};
                rd_addr  <= {frm.opcode[ADDR_HIGH_POS], next_byte};
                ptr      <= next_byte[1:0];
                st_data  <= next_byte;
            end
            if (next_cnt > CNT_ADDR) begin
                rd_addr <= rd_addr + 9'h001;
            end
            if (next_cnt > CNT_ADDR && op_is_wr) begin
                page_buf[ptr]     <= next_byte;
                frm.mask[ptr]     <= 1'b1;
                ptr               <= ptr + 2'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Output side, falling SCK
    // ---------------------------------------------------------------
    logic [7:0] status_view;
    wire  [7:0] tx_byte = op_is_st ? status_view : mem[rd_addr];
    wire        tx_want = (op_is_st && bit_cnt >= CNT_OPCODE) ||
                          (op_is_rd && bit_cnt >= CNT_ADDR);

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            tx_on <= 1'b0;
            so_q  <= 1'b0;
        end else begin
            tx_on <= tx_want;
            so_q  <= tx_byte[~phase];
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers, core clock
    // ---------------------------------------------------------------
    logic [3:0] pin_s1, pin_s2, pin_s3, pin_flt;
    logic       tgl_s1, tgl_s2, tgl_seen;
    logic       cs_d;
    wire  [3:0] pin_raw   = {reset_n_i, supply_ok, wp_n, cs_n};
    wire  [3:0] pin_agree = ~(pin_s2 ^ pin_s3);
    wire        cs_f      = pin_flt[0];
    wire        wp_f      = pin_flt[1];
    wire        sup_f     = pin_flt[2];
    wire        ext_rst_f = ~pin_flt[3];
    wire        cs_rise   = cs_f & ~cs_d;
    wire        cs_fall   = ~cs_f & cs_d;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1  <= PIN_FLT_RESET;
            pin_s2  <= PIN_FLT_RESET;
            pin_s3  <= PIN_FLT_RESET;
            pin_flt <= PIN_FLT_RESET;
            cs_d    <= 1'b1;
            tgl_s1  <= 1'b0;
            tgl_s2  <= 1'b0;
        end else begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_flt <= (pin_s2 & pin_agree) | (pin_flt & ~pin_agree);
            cs_d    <= cs_f;
            tgl_s1  <= frame_tgl;
            tgl_s2  <= tgl_s1;
        end
    end

    // ---------------------------------------------------------------
    // Command decode at deselect
    // ---------------------------------------------------------------
    spiwd_status_s st;
    spiwd_wstate_e wstate;
    logic [23:0]   busy_cnt;
    logic          cs_seen;
    logic          wp_lost;
    logic          wr_status;
    logic [7:0]    wr_st_data;
    logic [8:0]    wr_addr;
    logic [3:0]    wr_mask;
    logic [7:0]    wr_buf [0:3];

    wire busy      = (wstate == WE_BUSY);
    wire busy_end  = busy && (busy_cnt == 24'h000000);
    wire frame_ok  = cs_rise && cs_seen && (tgl_s2 != tgl_seen);
    wire page_cnt  = (bit_cnt[2:0] == 3'h0) && (bit_cnt >= CNT_PAGE_MIN) &&
                     (bit_cnt <= CNT_PAGE_MAX);
    wire wr_ok     = st.latch && !busy && wp_f && !wp_lost;
    // latch commands need exactly eight clocks
    wire do_set    = frame_ok && (bit_cnt == CNT_OPCODE) && (frm.opcode == OP_LATCH_SET);
    wire do_clr    = frame_ok && (bit_cnt == CNT_OPCODE) && (frm.opcode == OP_LATCH_CLEAR);
    // status and array writes gated by latch
    wire do_status_write_cmd   = frame_ok && wr_ok && (bit_cnt == CNT_ADDR) &&
                     (frm.opcode == OP_STATUS_WRITE);
    // array write only at valid counts
    wire do_wrarr  = frame_ok && wr_ok && page_cnt && op_is_wr;
    wire start_wr  = do_status_write_cmd || do_wrarr;

    // Select history and protect pin watch per frame
    // first falling select arms device
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_seen  <= 1'b0;
            wp_lost  <= 1'b0;
            tgl_seen <= 1'b0;
        end else begin
            if (cs_fall) begin
                cs_seen <= 1'b1;
            end
            if (cs_rise) begin
                tgl_seen <= tgl_s2;
            end
            wp_lost <= cs_fall ? ~wp_f : (wp_lost | (~cs_f & ~wp_f));
        end
    end

    // Write latch; protect pin wins, then set wins over completion clear
    // set, clear, clear after write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st.latch <= 1'b0;
        end else if (!wp_f) begin
            st.latch <= 1'b0;
        end else if (do_set) begin
            st.latch <= 1'b1;
        end else if (do_clr || busy_end) begin
            st.latch <= 1'b0;
        end
    end

    // Write engine; the frame is snapshotted so later frames cannot disturb it
    // busy for WRITE_LEN cycles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wstate    <= WE_IDLE;
            busy_cnt  <= 24'h000000;
            wr_status <= 1'b0;
            st.prot   <= PROT_RESET;
            st.wd     <= WD_RESET;
        end else begin
            case (wstate)
                WE_IDLE: begin
                    if (start_wr) begin
                        wstate    <= WE_BUSY;
                        busy_cnt  <= 24'(WRITE_LEN - 1);
                        wr_status <= do_status_write_cmd;
                    end
                end
                WE_BUSY: begin
                    busy_cnt <= busy_cnt - 24'h000001;
                    if (busy_end) begin
                        wstate <= WE_IDLE;
                        if (wr_status) begin
                            st.prot <= wr_st_data[ST_PROT_POS +: 2];
                            st.wd   <= wr_st_data[ST_WD_POS +: 2];
                        end
                    end
                end
                default: wstate <= WE_IDLE;
            endcase
        end
    end

    // Snapshot and array update; data only, no reset needed
    // locked bytes skipped
    always_ff @(posedge clk) begin
        if (start_wr && !busy) begin
            wr_addr    <= frm.addr;
            wr_mask    <= frm.mask;
            wr_st_data <= st_data;
            for (int i = 0; i < 4; i++) begin
                wr_buf[i] <= page_buf[i];
            end
        end
        if (busy_end && !wr_status) begin
            for (int i = 0; i < 4; i++) begin
                if (wr_mask[i] && !spiwd_locked(st.prot, {wr_addr[8:2], 2'(i)})) begin
                    mem[{wr_addr[8:2], 2'(i)}] <= wr_buf[i];
                end
            end
        end
    end

    // Status as seen by the host
    // field layout
    assign status_view = busy ? ST_BUSY_VIEW : {2'h0, st.wd, st.prot, st.latch, 1'b0};

    // ---------------------------------------------------------------
    // Time base, watchdog and reset output
    // ---------------------------------------------------------------
    logic [23:0] tick_cnt;
    logic [10:0] wd_cnt;
    logic [10:0] hold_cnt;
    logic        rst_drive;
    wire         tick    = (tick_cnt == 24'(TICK_LEN - 1));
    wire  [10:0] wd_lim  = (st.wd == 2'h0) ? WD_LONG_TICKS :
                           (st.wd == 2'h1) ? WD_MID_TICKS : WD_SHORT_TICKS;
    wire         wd_on   = (st.wd != WD_OFF);
    wire         wd_fire = wd_on && tick && (wd_cnt >= wd_lim - 11'h001);
    wire         wd_hold = cs_fall || rst_drive || ext_rst_f || !wd_on;

    // Tick restarts with each reset cause so a hold spans whole ticks
    // internal time base
    always_ff @(posedge clk) begin
        if (sys_rst || tick || !sup_f || wd_fire) begin
            tick_cnt <= 24'h000000;
        end else begin
            tick_cnt <= tick_cnt + 24'h000001;
        end
    end

    // Watchdog counts ticks since the last select falling edge
    // period select
    always_ff @(posedge clk) begin
        if (sys_rst || wd_hold) begin
            wd_cnt <= 11'h000;
        end else if (tick) begin
            wd_cnt <= wd_cnt + 11'h001;
        end
    end

    // Hold counter reloads on low supply or watchdog fire
    // low until supply good for hold
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_cnt  <= HOLD_TICKS;
            rst_drive <= 1'b1;
        end else begin
            if (!sup_f || wd_fire) begin
                hold_cnt <= HOLD_TICKS;
            end else if (tick && hold_cnt != 11'h000) begin
                hold_cnt <= hold_cnt - 11'h001;
            end
            rst_drive <= !sup_f || wd_fire || (hold_cnt != 11'h000);
        end
    end

    // Open drain: only ever pulls low
    assign reset_n_o  = 1'b0;
    assign reset_n_oe = rst_drive;
    assign so_o       = so_q;
    assign so_oe      = ~cs_n & tx_on & cs_seen;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    chk_busy_view: assert property (@(posedge clk) disable iff (sys_rst)
        busy |-> status_view == ST_BUSY_VIEW) else $error("status not all ones while busy");
    chk_latch_needed: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(busy) |-> $past(st.latch)) else $error("write started without latch");
    chk_wp_clears: assert property (@(posedge clk) disable iff (sys_rst)
        !wp_f |=> !st.latch) else $error("latch survived protect pin low");
    chk_latch_set: assert property (@(posedge clk) disable iff (sys_rst)
        do_set && wp_f |=> st.latch) else $error("latch set command lost");
    chk_latch_after_wr: assert property (@(posedge clk) disable iff (sys_rst)
        busy_end && !do_set |=> !st.latch && !busy) else $error("latch kept after write");
    chk_before_fall: assert property (@(posedge clk) disable iff (sys_rst)
        !cs_seen |=> !$rose(st.latch) && !$rose(busy)) else $error("accepted before select fall");
    chk_page_count: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(busy) && !wr_status |-> $past(page_cnt)) else $error("write at bad clock count");
    chk_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
        busy && busy_cnt != 24'h000000 |=> busy && busy_cnt == $past(busy_cnt) - 24'h000001)
        else $error("busy ended early");
    chk_supply_rst: assert property (@(posedge clk) disable iff (sys_rst)
        !sup_f |=> reset_n_oe ##1 reset_n_oe) else $error("reset not driven on low supply");
    chk_wd_restart: assert property (@(posedge clk) disable iff (sys_rst)
        cs_fall |=> wd_cnt == 11'h000) else $error("watchdog not restarted");
    chk_so_release: assert property (@(posedge clk) disable iff (sys_rst)
        cs_n |-> !so_oe && !tx_on) else $error("SO driven while deselected");
    chk_rd_wrap: assert property (@(posedge sck) disable iff (cs_n)
        in_frame && phase == 3'h0 && bit_cnt > CNT_ADDR |->
        rd_addr == 9'($past(rd_addr) + 9'h001)) else $error("read address step wrong");

    cov_status_busy: cover property (@(posedge clk) busy && !cs_f && op_is_st);
    cov_page_four:   cover property (@(posedge clk) do_wrarr && bit_cnt == CNT_PAGE_MAX);
    cov_wd_fire:     cover property (@(posedge clk) wd_fire);
    cov_rd_wrap:     cover property (@(posedge sck) rd_addr == 9'h000 && bit_cnt > CNT_PAGE_MIN);
endmodule
`default_nettype wire

// File: verification/spiwd_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link; sck rests low between frames
module spiwd_host (
    output logic     sck,
    output logic     cs_n,
    output logic     si,
    input  wire logic so
);
    // Non-blocking, so the design sees select rise from unknown and clears its frame
    initial begin
        sck <= 1'b0;
        cs_n <= 1'b1;
        si <= 1'b0;
    end
    task automatic sel;
        cs_n <= 1'b0;
        #100;
    endtask
    // MSB first, SI settled well before each rise
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            #32 sck <= 1'b1;
            #1 rx[i] = so;
            #31 sck <= 1'b0;
        end
    endtask
    // release only after whole bytes; idle SI must not look held
    task automatic rel;
        #32 cs_n <= 1'b1;
        si <= ~si;
        #400;
    endtask
endmodule
`default_nettype wire

// File: verification/spi_eeprom_watchdog_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_watchdog_supervisor_test
    import spiwd_pkg::*;
();
    logic       clk         = 1'b0;
    logic       sys_rst;
    logic       wp_n        = 1'b1;
    logic       supply_ok   = 1'b1;
    int         miscompares = 0;
    int         n_compared  = 0;
    logic [7:0] b [7];
    wire logic  sck, cs_n, si, so_o, so_oe, reset_n_o, reset_n_oe;
    // Pulled-up reset wire; undriven SO shows the inverse, not a stale bit
    wire logic  reset_n_i = ~reset_n_oe;
    wire logic  so_line   = so_oe ? so_o : ~so_o;

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    // Short tick and write cycle keep the run small
    spiwd_top #(.TICK_LEN(20), .WRITE_LEN(100)) spiwd_top_i (
        .clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
        .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n), .supply_ok(supply_ok),
        .reset_n_i(reset_n_i), .reset_n_o(reset_n_o), .reset_n_oe(reset_n_oe)
    );
    spiwd_host spiwd_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One frame of n bytes, right-aligned in v; replies land in b
    task automatic go(input int n, input logic [55:0] v);
        for (int k = 0; k < n; k++) b[k] = v[8 * (n - 1 - k) +: 8];
        spiwd_host_i.sel();
        for (int k = 0; k < n; k++) spiwd_host_i.xb(b[k], b[k]);
        spiwd_host_i.rel();
    endtask
    task automatic st(input logic [7:0] exp, input string nm);
        go(2, {OP_STATUS_READ, 8'h00});
        chk(nm, b[1], exp);
    endtask
    // Bounded poll; a stuck busy flag ends in a mismatch
    task automatic wait_idle;
        b[1] = 8'h01;
        for (int i = 0; i < 40 && b[1][0] !== 1'b0; i++) go(2, {OP_STATUS_READ, 8'h00});
        chk("busy_clear", {7'h0, b[1][0]}, 8'h00);
    endtask
    task automatic set_status(input logic [7:0] v);
        go(1, OP_LATCH_SET);
        go(2, {OP_STATUS_WRITE, v});
        wait_idle();
    endtask
    task automatic span(input string nm, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (reset_n_oe !== v && n < 9000) begin
            @(posedge clk);
            n++;
        end
        chk(nm, {7'h0, n >= lo && n <= hi}, 8'h01);
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_power;
        span("por_hold", 1'b0, 3990, 4045);
        @(posedge clk) supply_ok <= 1'b0;
        repeat (10) @(posedge clk);
        chk("low_supply", {7'h0, reset_n_oe}, 8'h01);
        chk("reset_level", {7'h0, reset_n_o}, 8'h00);
        supply_ok <= 1'b1;
        span("supply_hold", 1'b0, 3990, 4045);
        $display("test power done");
    endtask
    task automatic t_latch;
        st(8'h30, "after_reset");
        chk("so_released", {7'h0, so_oe}, 8'h00);
        go(1, OP_LATCH_SET);
        st(8'h32, "latch_set");
        go(1, OP_LATCH_CLEAR);
        st(8'h30, "latch_clear");
        go(2, {OP_LATCH_SET, 8'h00});
        st(8'h30, "set_too_long");
        $display("test latch done");
    endtask
    task automatic t_page;
        go(1, OP_LATCH_SET);
        go(3, {OP_ARRAY_WRITE, 16'h005a});
        st(8'hff, "busy_view");
        wait_idle();
        st(8'h30, "latch_auto_clear");
        go(1, OP_LATCH_SET);
        go(6, {OP_ARRAY_WRITE | 8'h08, 40'hfe11223344});
        wait_idle();
        go(1, OP_LATCH_SET);
        go(7, {OP_ARRAY_WRITE | 8'h08, 48'hfc9999999999});
        st(8'h32, "cut_at_56");
        go(1, OP_LATCH_CLEAR);
        go(6, {OP_ARRAY_READ | 8'h08, 40'hfd00000000});
        chk("page_1fd", b[2], 8'h44);
        chk("page_1fe", b[3], 8'h11);
        chk("page_1ff", b[4], 8'h22);
        chk("wrap_000", b[5], 8'h5a);
        $display("test page done");
    endtask
    task automatic t_guard;
        go(3, {OP_ARRAY_WRITE, 16'h0077});
        st(8'h30, "no_latch_no_busy");
        go(1, OP_LATCH_SET);
        @(posedge clk) wp_n <= 1'b0;
        repeat (8) @(posedge clk);
        st(8'h30, "wp_clears_latch");
        @(posedge clk) wp_n <= 1'b1;
        set_status(8'h3c);
        st(8'h3c, "protect_all");
        go(1, OP_LATCH_SET);
        go(3, {OP_ARRAY_WRITE, 16'h00a5});
        wait_idle();
        go(3, {OP_ARRAY_READ, 16'h0000});
        chk("locked_keep", b[2], 8'h5a);
        $display("test guard done");
    endtask
    task automatic t_watchdog;
        set_status(8'h2c);
        span("wd_fire", 1'b1, 3880, 4020);
        span("wd_hold", 1'b0, 3970, 4045);
        $display("test watchdog done");
    endtask

    // Main sequence
    initial begin
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_power();
        t_latch();
        t_page();
        t_guard();
        t_watchdog();
        give_verdict();
    end
    // Hang guard, well past the expected run length
    initial begin
        #2000000;
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
